// ---- shared/pdcs_pkg.sv ----
// Package with offsets, field layouts, reset values and carrier types for the device control/status pair.
package pdcs_pkg;

   // Register offsets relative to the express_capability_base, as byte offsets.
   localparam logic [7:0]  DEVICE_CONTROL_OFS = 8'h08;   // device_control_register
   localparam logic [7:0]  DEVICE_STATUS_OFS  = 8'h0A;   // device_status_register

   // Bit positions inside the two 16-bit registers and the capabilities word.
   localparam int unsigned CTRL_FLR_BIT   = 15;          // Write-one reset trigger, reads as zero.
   localparam int unsigned STAT_TP_BIT    = 5;           // transactions_pending.
   localparam int unsigned STAT_AUX_BIT   = 4;           // aux_power_present.
   localparam int unsigned STAT_ERR_MSB   = 3;           // Error flags occupy bits 3:0.
   localparam int unsigned CAP_FLR_BIT    = 28;          // function_reset_capable in the capabilities word.

   // Reset values of the control fields.
   localparam logic [2:0]  READ_REQUEST_SIZE_LIMIT_RESET     = 3'h2;        // read_request_size_limit reset value.
   localparam logic [2:0]  MPS_RESET      = 3'h0;        // max_payload_limit resets to 000b.
   localparam logic        RO_RESET       = 1'h0;        // relaxed_order_enable reset value.
   localparam logic [15:0] STAT_RSVD_MASK = 16'hFFC0;    // Reserved status bits, always read zero.

   // Size encoding: code n means 128 << n bytes.
   localparam logic [12:0] SIZE_BASE_BYTES = 13'h0080;   // 128 bytes for code 000b.
   localparam logic [7:0]  TAG_MASK_WIDE   = 8'hFF;      // 8-bit tag space.
   localparam logic [7:0]  TAG_MASK_NARROW = 8'h1F;      // 5-bit tag space.

   // Control fields in register order; the struct maps exactly onto bits 14:0.
   typedef struct packed {
      logic [2:0] read_request_size_limit;
      logic       no_snoop_enable;
      logic       aux_power_enable;
      logic       phantom_function_enable;
      logic       wide_tag_enable;
      logic [2:0] max_payload_limit;
      logic       relaxed_order_enable;
      logic       unsupported_request_report_enable;
      logic       fatal_error_report_enable;
      logic       nonfatal_error_report_enable;
      logic       correctable_error_report_enable;
   } pdcs_ctrl_s;

   // Error events and flags in status register order, bits 3:0.
   typedef struct packed {
      logic unsupported_request_seen;
      logic fatal_error_seen;
      logic nonfatal_error_seen;
      logic correctable_error_seen;
   } pdcs_err_s;

   // Error message requests towards the message generator.
   typedef struct packed {
      logic err_fatal;
      logic err_nonfatal;
      logic err_cor;
   } pdcs_msg_s;

   // Control reset value assembled from the field reset values.
   localparam pdcs_ctrl_s CTRL_RESET = '{read_request_size_limit: READ_REQUEST_SIZE_LIMIT_RESET, max_payload_limit: MPS_RESET,
                                         relaxed_order_enable: RO_RESET, default: 1'b0};

endpackage

// ---- hw/pdcs_regs.sv ----
// Device control and device status registers of the express capability, with their side logic.
`timescale 1ns/1ps
// How it works
// - Writing one to bit 15 starts function reset.
// - Bit 15 always reads back as zero.
// - Read requests never exceed selected read size.
// - No Snoop attribute only while enabled.
// - Aux power draw only while enabled.
// - Phantom functions used only while enabled.
// - Wide tags only when enabled, else 5-bit.
// - Payload limit field resets to zero, caps transmission.
// - Payload field may be hardwired to zero.
// - Relaxed Ordering attribute only while enabled.
// - Unsupported request enable gates error messages.
// - Fatal enable gates fatal messages.
// - Non-fatal enable gates non-fatal messages.
// - Correctable enable gates correctable messages.
// - Pending bit set while requests outstanding.
// - Pending bit clears only when all finished.
// - Completed function reset clears pending bit.
// - Aux power present bit follows detection.
// - Unsupported request flag set on reception.
// - Severity flags set on matching detected errors.
// - Flags record errors regardless of enables.
// - Function reset capability bit reads one.
module pdcs_regs
   import pdcs_pkg::*;
#(
   parameter logic [14:0] CTRL_WR_MASK = 15'h7FFF,   // One marks a writable control bit, zero a hardwired one.
   parameter int unsigned NP_CNT_W     = 8            // Width of the outstanding request counter.
)(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        CFG_WR,
   input  wire logic        CFG_RD,
   input  wire logic [7:0]  CFG_ADDR,
   input  wire logic [1:0]  CFG_BE,
   input  wire logic [15:0] CFG_WDATA,
   output logic      [15:0] CFG_RDATA,
   output logic             CFG_RD_VALID,
   output logic      [31:0] CAP_WORD,
   output pdcs_ctrl_s       DEV_CTRL,
   output logic             FLR_START,
   output logic             FLR_BUSY,
   input  wire logic        FLR_DONE,
   input  wire logic        NP_ISSUE,
   input  wire logic        NP_DONE,
   output logic             TRANSACTIONS_PENDING,
   input  wire logic        AUX_DETECT,
   output logic             AUX_DRAW_OK,
   input  wire pdcs_err_s   ERR_EVT,
   input  wire logic        SERR_EN,
   output pdcs_msg_s        ERR_MSG,
   input  wire logic [12:0] REQ_RD_BYTES,
   output logic             RD_LEN_OK,
   input  wire logic [12:0] TX_PL_BYTES,
   output logic             TX_LEN_OK,
   output logic [12:0]      MAX_PAYLOAD_BYTES,
   output logic [7:0]       TAG_MASK,
   output logic             PHANTOM_OK,
   input  wire logic        WANT_NO_SNOOP,
   output logic             NO_SNOOP_ATTR,
   input  wire logic        WANT_RELAXED,
   output logic             RELAXED_ATTR
);

   // Converts a 3-bit size code into a byte count; codes above 101b saturate at 4096.
   function automatic logic [12:0] size_bytes(input logic [2:0] code);
      logic [2:0] c;
      c = (code > 3'h5) ? 3'h5 : code;
      size_bytes = 13'(SIZE_BASE_BYTES << c);
   endfunction

   pdcs_ctrl_s            ctrl_reg;        // Control fields.
   pdcs_ctrl_s            ctrl_next;
   pdcs_err_s             err_reg;         // Sticky error flags.
   pdcs_err_s             err_next;
   logic                  aux_reg;         // Registered aux power detection.
   logic                  aux_next;
   logic [NP_CNT_W-1:0]   np_cnt_reg;      // Outstanding non-posted requests.
   logic [NP_CNT_W-1:0]   np_cnt_next;
   logic                  flr_start_reg;   // One-cycle reset trigger pulse.
   logic                  flr_start_next;
   logic                  flr_busy_reg;    // Function reset in progress.
   logic                  flr_busy_next;
   pdcs_msg_s             msg_reg;         // Gated error message requests.
   pdcs_msg_s             msg_next;
   logic [15:0]           rdata_reg;       // Read data.
   logic [15:0]           rdata_next;
   logic                  rvalid_reg;      // Read answer strobe.
   logic                  rvalid_next;
   logic                  wr_ctrl;         // Write hits the control register.
   logic                  wr_stat;         // Write hits the status register.
   logic [15:0]           stat_word;       // Assembled status value.
   logic [15:0]           wmask;           // Byte enables spread to bits.

   // Address decode of configuration writes and byte enable expansion.
   always_comb begin
      wr_ctrl = CFG_WR && (CFG_ADDR == DEVICE_CONTROL_OFS);
      wr_stat = CFG_WR && (CFG_ADDR == DEVICE_STATUS_OFS);
      wmask   = {{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
   end

   // Status word; reserved bits stay zero.
   always_comb begin
      stat_word                           = 16'h0000;
      stat_word[STAT_TP_BIT]              = np_cnt_reg != '0;
      stat_word[STAT_AUX_BIT]             = aux_reg;
      stat_word[STAT_ERR_MSB:0]           = err_reg;
      stat_word                           = stat_word & ~STAT_RSVD_MASK;
   end

   // Next values of control, status, pending counter and function reset state.
   always_comb begin
      ctrl_next      = ctrl_reg;
      err_next       = err_reg;
      np_cnt_next    = np_cnt_reg;
      aux_next       = AUX_DETECT;
      flr_start_next = 1'b0;
      flr_busy_next  = flr_busy_reg;
      if (wr_ctrl) begin
         // Only writable bits in enabled bytes change; hardwired bits keep their reset value.
         ctrl_next = pdcs_ctrl_s'((CFG_WDATA[14:0] & wmask[14:0] & CTRL_WR_MASK)
                                | (ctrl_reg & ~(wmask[14:0] & CTRL_WR_MASK)));
         // The trigger bit is not stored, it only launches the reset.
         flr_start_next = CFG_BE[1] && CFG_WDATA[CTRL_FLR_BIT];
         flr_busy_next  = flr_busy_reg || flr_start_next;
      end
      // Write one clears a flag; a new event in the same cycle wins.
      if (wr_stat && CFG_BE[0]) begin
         err_next = pdcs_err_s'(err_reg & ~CFG_WDATA[STAT_ERR_MSB:0]);
      end
      // Errors are logged whatever the report enables say.
      err_next = pdcs_err_s'(err_next | ERR_EVT);
      // Outstanding count: issue adds, completion or timeout subtracts, saturating both ways.
      if (NP_ISSUE && !NP_DONE && (np_cnt_reg != '1)) begin
         np_cnt_next = np_cnt_reg + 1'b1;
      end else if (NP_DONE && !NP_ISSUE && (np_cnt_reg != '0)) begin
         np_cnt_next = np_cnt_reg - 1'b1;
      end
      // A finished function reset returns the function to its reset state.
      if (FLR_DONE && flr_busy_reg) begin
         ctrl_next     = CTRL_RESET;
         err_next      = '0;
         np_cnt_next   = '0;
         // A trigger written in the same cycle starts the next reset, so busy stays up then.
         flr_busy_next = flr_start_next;
      end
   end

   // Registers for control, status and reset state.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ctrl_reg      <= CTRL_RESET;
         err_reg       <= '0;
         np_cnt_reg    <= '0;
         aux_reg       <= 1'b0;
         flr_start_reg <= 1'b0;
         flr_busy_reg  <= 1'b0;
      end else begin
         ctrl_reg      <= ctrl_next;
         err_reg       <= err_next;
         np_cnt_reg    <= np_cnt_next;
         aux_reg       <= aux_next;
         flr_start_reg <= flr_start_next;
         flr_busy_reg  <= flr_busy_next;
      end
   end

   // Read path and error message gating.
   always_comb begin
      rvalid_next = CFG_RD;
      rdata_next  = 16'h0000;
      if (CFG_RD && (CFG_ADDR == DEVICE_CONTROL_OFS)) begin
         rdata_next = {1'b0, ctrl_reg};
      end else if (CFG_RD && (CFG_ADDR == DEVICE_STATUS_OFS)) begin
         rdata_next = stat_word;
      end
      // Unsupported requests go out as non-fatal messages under their own enable.
      msg_next.err_fatal    = ERR_EVT.fatal_error_seen
                              && (ctrl_reg.fatal_error_report_enable || SERR_EN);
      msg_next.err_nonfatal = (ERR_EVT.nonfatal_error_seen
                              && (ctrl_reg.nonfatal_error_report_enable || SERR_EN))
                              || (ERR_EVT.unsupported_request_seen
                              && ctrl_reg.unsupported_request_report_enable);
      msg_next.err_cor      = ERR_EVT.correctable_error_seen
                              && ctrl_reg.correctable_error_report_enable;
   end

   // Registers for read data and messages.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         rdata_reg  <= 16'h0000;
         rvalid_reg <= 1'b0;
         msg_reg    <= '0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
         msg_reg    <= msg_next;
      end
   end

   // Outputs towards the host side and the function's requester logic.
   always_comb begin
      CFG_RDATA            = rdata_reg;
      CFG_RD_VALID         = rvalid_reg;
      CAP_WORD             = 32'h0000_0000;
      CAP_WORD[CAP_FLR_BIT] = 1'b1;
      DEV_CTRL             = ctrl_reg;
      FLR_START            = flr_start_reg;
      FLR_BUSY             = flr_busy_reg;
      TRANSACTIONS_PENDING = stat_word[STAT_TP_BIT];
      AUX_DRAW_OK          = ctrl_reg.aux_power_enable;
      ERR_MSG              = msg_reg;
      RD_LEN_OK            = REQ_RD_BYTES <= size_bytes(ctrl_reg.read_request_size_limit);
      MAX_PAYLOAD_BYTES    = size_bytes(ctrl_reg.max_payload_limit);
      TX_LEN_OK            = TX_PL_BYTES <= size_bytes(ctrl_reg.max_payload_limit);
      TAG_MASK             = ctrl_reg.wide_tag_enable ? TAG_MASK_WIDE : TAG_MASK_NARROW;
      PHANTOM_OK           = ctrl_reg.phantom_function_enable;
      NO_SNOOP_ATTR        = WANT_NO_SNOOP && ctrl_reg.no_snoop_enable;
      RELAXED_ATTR         = WANT_RELAXED && ctrl_reg.relaxed_order_enable;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   // Trigger write followed by the reset pulse and the busy level.
   sequence flr_write_s;
      wr_ctrl && CFG_BE[1] && CFG_WDATA[CTRL_FLR_BIT];
   endsequence
   sequence flr_launch_s;
      FLR_START && FLR_BUSY;
   endsequence

   flr_launch_a: assert property (flr_write_s |=> flr_launch_s) else $error("reset trigger not launched");
   flr_reads_zero_a: assert property (CFG_RD_VALID |-> !CFG_RDATA[CTRL_FLR_BIT])
      else $error("trigger bit read as one");
   // The bound is worked out at 16 bits so that codes 110b and 111b do not wrap.
   rd_size_cap_a: assert property (RD_LEN_OK |-> {3'h0, REQ_RD_BYTES}
      <= (16'(SIZE_BASE_BYTES) << DEV_CTRL.read_request_size_limit)) else $error("read length above limit");
   no_snoop_gate_a: assert property (NO_SNOOP_ATTR |-> DEV_CTRL.no_snoop_enable)
      else $error("no snoop without enable");
   tag_width_a: assert property (!DEV_CTRL.wide_tag_enable |-> TAG_MASK == TAG_MASK_NARROW)
      else $error("wide tags without enable");
   cor_msg_gate_a: assert property (ERR_MSG.err_cor
      |-> $past(DEV_CTRL.correctable_error_report_enable)) else $error("correctable message without enable");
   pending_set_a: assert property (NP_ISSUE && !NP_DONE && !FLR_DONE |=> TRANSACTIONS_PENDING)
      else $error("pending bit not set");
   pending_clear_a: assert property ($fell(TRANSACTIONS_PENDING)
      |-> $past(np_cnt_reg) <= 1 || $past(FLR_DONE)) else $error("pending bit cleared early");
   flr_done_clear_a: assert property (FLR_DONE && FLR_BUSY |=> !TRANSACTIONS_PENDING && err_reg == '0)
      else $error("reset completion left state");
   err_log_a: assert property (ERR_EVT.fatal_error_seen && !(FLR_DONE && FLR_BUSY)
      |=> err_reg.fatal_error_seen) else $error("fatal error not logged");
   rw1c_clear_a: assert property (wr_stat && CFG_BE[0] && CFG_WDATA[0]
      && !ERR_EVT.correctable_error_seen |=> !err_reg.correctable_error_seen) else $error("write one did not clear");

endmodule

// ---- testbench/pdcs_host_model.sv ----
// Host model that issues configuration reads and writes to the register pair.
`timescale 1ns/1ps
module pdcs_host_model (
   input  wire logic        CLK,
   output logic             CFG_WR,
   output logic             CFG_RD,
   output logic [7:0]       CFG_ADDR,
   output logic [1:0]       CFG_BE,
   output logic [15:0]      CFG_WDATA,
   input  wire logic [15:0] CFG_RDATA,
   input  wire logic        CFG_RD_VALID
);
   // Idle state of the request lines at time zero.
   initial begin
      CFG_WR    = 1'b0;
      CFG_RD    = 1'b0;
      CFG_ADDR  = 8'hFF;
      CFG_BE    = 2'h0;
      CFG_WDATA = 16'hFFFF;
   end
   // One write; the rising edge between the two falling edges takes it.
   // Released lines carry the inverse so no stale value looks like a request.
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(negedge CLK);
      CFG_WR    = 1'b1;
      CFG_ADDR  = a;
      CFG_BE    = be;
      CFG_WDATA = d;
      @(negedge CLK);
      CFG_WR    = 1'b0;
      CFG_ADDR  = ~a;
      CFG_BE    = ~be;
      CFG_WDATA = ~d;
   endtask
   // One read; the answer stands in the cycle after the taking edge.
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
      @(negedge CLK);
      CFG_RD   = 1'b1;
      CFG_ADDR = a;
      @(negedge CLK);
      CFG_RD   = 1'b0;
      CFG_ADDR = ~a;
      ok       = CFG_RD_VALID;
      d        = CFG_RDATA;
   endtask
endmodule

// ---- testbench/tb_pcie_device_control_status_regs.sv ----
// Self-checking bench for the device control and status register pair.
`timescale 1ns/1ps
module tb_pcie_device_control_status_regs import pdcs_pkg::*; ;
   logic        CLK = 1'b0;                                  // 10 MHz clock.
   logic        RESET_N = 1'b0;                              // Synchronous reset, active low.
   logic        FLR_DONE = 1'b0, NP_ISSUE = 1'b0, NP_DONE = 1'b0;  // Bench-driven pulses.
   logic        AUX_DETECT = 1'b0, SERR_EN = 1'b0;           // Bench-driven levels.
   logic        WANT_NO_SNOOP = 1'b0, WANT_RELAXED = 1'b0;   // Attribute requests.
   logic [12:0] REQ_RD_BYTES = 13'h0000, TX_PL_BYTES = 13'h0000;  // Lengths under test.
   pdcs_err_s   ERR_EVT = 4'h0;                              // Error event pulses.
   logic        CFG_WR, CFG_RD, CFG_RD_VALID, FLR_START, FLR_BUSY, TP;
   logic        AUX_DRAW_OK, RD_LEN_OK, TX_LEN_OK, PHANTOM_OK, NO_SNOOP_ATTR, RELAXED_ATTR;
   logic [7:0]  CFG_ADDR, TAG_MASK;
   logic [1:0]  CFG_BE;
   logic [15:0] CFG_WDATA, CFG_RDATA;
   logic [31:0] CAP_WORD;
   logic [12:0] MAX_PAYLOAD_BYTES;
   pdcs_ctrl_s  DEV_CTRL;
   pdcs_msg_s   ERR_MSG;
   pdcs_ctrl_s  DEV_CTRL_FIXED;                              // Control fields of the copy with a fixed payload field.
   logic [12:0] MPS_FIXED_BYTES;                             // Payload limit of that copy.
   int          bad_count = 0, total_checks = 0, cycles = 0;  // Verdict counters.

   always #50 CLK = ~CLK;

   pdcs_host_model host (.CLK(CLK), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
      .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_RD_VALID(CFG_RD_VALID));

   pdcs_regs dut (.CLK(CLK), .RESET_N(RESET_N), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
      .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
      .CFG_RD_VALID(CFG_RD_VALID), .CAP_WORD(CAP_WORD), .DEV_CTRL(DEV_CTRL), .FLR_START(FLR_START),
      .FLR_BUSY(FLR_BUSY), .FLR_DONE(FLR_DONE), .NP_ISSUE(NP_ISSUE), .NP_DONE(NP_DONE),
      .TRANSACTIONS_PENDING(TP), .AUX_DETECT(AUX_DETECT), .AUX_DRAW_OK(AUX_DRAW_OK),
      .ERR_EVT(ERR_EVT), .SERR_EN(SERR_EN), .ERR_MSG(ERR_MSG), .REQ_RD_BYTES(REQ_RD_BYTES),
      .RD_LEN_OK(RD_LEN_OK), .TX_PL_BYTES(TX_PL_BYTES), .TX_LEN_OK(TX_LEN_OK),
      .MAX_PAYLOAD_BYTES(MAX_PAYLOAD_BYTES), .TAG_MASK(TAG_MASK), .PHANTOM_OK(PHANTOM_OK),
      .WANT_NO_SNOOP(WANT_NO_SNOOP), .NO_SNOOP_ATTR(NO_SNOOP_ATTR), .WANT_RELAXED(WANT_RELAXED),
      .RELAXED_ATTR(RELAXED_ATTR));

   // Second copy with the payload field hardwired to 000b; it sees the same writes as the first.
   pdcs_regs #(.CTRL_WR_MASK(15'h7F1F), .NP_CNT_W(8)) dut_fixed (.CLK(CLK), .RESET_N(RESET_N), .CFG_WR(CFG_WR),
      .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(), .CFG_RD_VALID(),
      .CAP_WORD(), .DEV_CTRL(DEV_CTRL_FIXED), .FLR_START(), .FLR_BUSY(), .FLR_DONE(FLR_DONE), .NP_ISSUE(NP_ISSUE),
      .NP_DONE(NP_DONE), .TRANSACTIONS_PENDING(), .AUX_DETECT(AUX_DETECT), .AUX_DRAW_OK(), .ERR_EVT(ERR_EVT),
      .SERR_EN(SERR_EN), .ERR_MSG(), .REQ_RD_BYTES(REQ_RD_BYTES), .RD_LEN_OK(), .TX_PL_BYTES(TX_PL_BYTES),
      .TX_LEN_OK(), .MAX_PAYLOAD_BYTES(MPS_FIXED_BYTES), .TAG_MASK(), .PHANTOM_OK(), .WANT_NO_SNOOP(WANT_NO_SNOOP),
      .NO_SNOOP_ATTR(), .WANT_RELAXED(WANT_RELAXED), .RELAXED_ATTR());

   // Compares one value with case equality and counts the result.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Reads one register and compares the answer pulse and the data.
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic        ok;
      host.rd(a, d, ok);
      chk(ok, 1'b1);
      chk(d, exp);
   endtask
   // Raises error events and request pulses for exactly one cycle.
   task automatic pulse(input logic [3:0] e, input logic iss, input logic dn);
      @(negedge CLK);
      ERR_EVT  = e;
      NP_ISSUE = iss;
      NP_DONE  = dn;
      @(negedge CLK);
      ERR_EVT  = 4'h0;
      NP_ISSUE = 1'b0;
      NP_DONE  = 1'b0;
   endtask
   // Reset values and the fixed capability word.
   task automatic t_reset;
      chk(CAP_WORD, 32'h0000_0001 << CAP_FLR_BIT);
      rchk(DEVICE_CONTROL_OFS, {1'b0, CTRL_RESET});
      rchk(DEVICE_STATUS_OFS, 16'h0000);
   endtask
   // Enables gate attributes, tags and aux draw; byte lanes and unmapped places.
   task automatic t_ctrl;
      WANT_NO_SNOOP = 1'b1;
      WANT_RELAXED  = 1'b1;
      host.wr(DEVICE_CONTROL_OFS, 2'h3, 16'h0F10);
      rchk(DEVICE_CONTROL_OFS, 16'h0F10);
      chk({NO_SNOOP_ATTR, AUX_DRAW_OK, PHANTOM_OK, RELAXED_ATTR}, 4'hF);
      chk(TAG_MASK, TAG_MASK_WIDE);
      host.wr(DEVICE_CONTROL_OFS, 2'h1, 16'hFF00);
      chk({DEV_CTRL, RELAXED_ATTR, TAG_MASK}, {15'h0F00, 1'b0, TAG_MASK_WIDE});
      host.wr(DEVICE_CONTROL_OFS, 2'h2, 16'h00FF);
      chk({NO_SNOOP_ATTR, AUX_DRAW_OK, PHANTOM_OK, RELAXED_ATTR}, 4'h0);
      chk(TAG_MASK, TAG_MASK_NARROW);
      host.wr(8'h0C, 2'h3, 16'h0F10);
      rchk(DEVICE_CONTROL_OFS, 16'h0000);
      rchk(8'h0C, 16'h0000);
      WANT_NO_SNOOP = 1'b0;
      WANT_RELAXED  = 1'b0;
   endtask
   // Every size code against its limit and one byte past it.
   task automatic t_sizes;
      logic [2:0]  m;
      logic [2:0]  p;
      logic [12:0] lim;
      for (int c = 0; c < 8; c++) begin
         m = 3'(c);
         p = (m > 3'h5) ? 3'h5 : m;
         lim = SIZE_BASE_BYTES << p;
         host.wr(DEVICE_CONTROL_OFS, 2'h3, {1'b0, m, 4'h0, m, 5'h00});
         chk({DEV_CTRL_FIXED, MPS_FIXED_BYTES}, {m, 4'h0, 3'h0, 5'h00, SIZE_BASE_BYTES});
         REQ_RD_BYTES = lim;
         TX_PL_BYTES  = lim;
         @(negedge CLK);
         chk({RD_LEN_OK, TX_LEN_OK, MAX_PAYLOAD_BYTES}, {2'h3, lim});
         REQ_RD_BYTES = lim + 13'h0001;
         TX_PL_BYTES  = lim + 13'h0001;
         @(negedge CLK);
         chk({RD_LEN_OK, TX_LEN_OK}, 2'h0);
      end
   endtask
   // Flags record with reporting off; write one clears; each enable gates its message.
   task automatic t_errors;
      host.wr(DEVICE_CONTROL_OFS, 2'h3, 16'h0000);
      pulse(4'hF, 1'b0, 1'b0);
      chk(ERR_MSG, 3'h0);
      rchk(DEVICE_STATUS_OFS, 16'h000F);
      host.wr(DEVICE_STATUS_OFS, 2'h1, 16'hFFF5);
      rchk(DEVICE_STATUS_OFS, 16'h000A);
      host.wr(DEVICE_STATUS_OFS, 2'h1, 16'h000A);
      rchk(DEVICE_STATUS_OFS, 16'h0000);
      host.wr(DEVICE_CONTROL_OFS, 2'h1, 16'h0008);
      pulse(4'h8, 1'b0, 1'b0);
      chk(ERR_MSG, 3'h2);
      // Each severity error alone, with all three severity enables on and the system error enable off.
      host.wr(DEVICE_CONTROL_OFS, 2'h1, 16'h0007);
      for (int i = 0; i < 3; i++) begin
         pulse(4'h1 << i, 1'b0, 1'b0);
         chk(ERR_MSG, 3'h1 << i);
      end
      // System error enable alone lets fatal and non-fatal out, never correctable.
      SERR_EN = 1'b1;
      host.wr(DEVICE_CONTROL_OFS, 2'h1, 16'h0000);
      pulse(4'h7, 1'b0, 1'b0);
      chk(ERR_MSG, 3'h6);
      SERR_EN = 1'b0;
      host.wr(DEVICE_STATUS_OFS, 2'h1, 16'h000F);
   endtask
   // Pending bit follows the count of outstanding requests; aux detection shows.
   task automatic t_pending;
      pulse(4'h0, 1'b0, 1'b1);
      pulse(4'h0, 1'b1, 1'b0);
      chk(TP, 1'b1);
      pulse(4'h0, 1'b1, 1'b0);
      pulse(4'h0, 1'b1, 1'b1);
      pulse(4'h0, 1'b0, 1'b1);
      chk(TP, 1'b1);
      AUX_DETECT = 1'b1;
      rchk(DEVICE_STATUS_OFS, 16'h0030);
      AUX_DETECT = 1'b0;
      pulse(4'h0, 1'b0, 1'b1);
      chk(TP, 1'b0);
   endtask
   // Function reset: stray done, low lane only, launch, read back, completion.
   task automatic t_flr;
      host.wr(DEVICE_CONTROL_OFS, 2'h3, 16'h0F10);
      pulse(4'h1, 1'b1, 1'b0);
      @(negedge CLK);
      FLR_DONE = 1'b1;
      @(negedge CLK);
      FLR_DONE = 1'b0;
      chk({FLR_BUSY, DEV_CTRL, TP}, {1'b0, 15'h0F10, 1'b1});
      host.wr(DEVICE_CONTROL_OFS, 2'h1, 16'h8000);
      chk(FLR_START, 1'b0);
      host.wr(DEVICE_CONTROL_OFS, 2'h2, 16'h8F10);
      chk({FLR_START, FLR_BUSY}, 2'h3);
      @(negedge CLK);
      chk({FLR_START, FLR_BUSY}, 2'h1);
      rchk(DEVICE_CONTROL_OFS, 16'h0F00);
      @(negedge CLK);
      FLR_DONE = 1'b1;
      @(negedge CLK);
      FLR_DONE = 1'b0;
      chk({FLR_BUSY, DEV_CTRL, TP}, {1'b0, CTRL_RESET, 1'b0});
      rchk(DEVICE_STATUS_OFS, 16'h0000);
   endtask
   // Prints the verdict and ends the run.
   task automatic tally_and_finish;
      if (bad_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Cuts a hang short; the tests need well under a thousand cycles.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         tally_and_finish;
      end
   end
   // Main sequence: reset for 20 cycles, then each scenario in turn.
   initial begin
      repeat (20) @(negedge CLK);
      RESET_N = 1'b1;
      t_reset;
      t_ctrl;
      t_sizes;
      t_errors;
      t_pending;
      t_flr;
      tally_and_finish;
   end
endmodule
